// ---- src/upfc_pkg.sv ----
// Purpose: constants for the uart pin function configuration block
// Assumes: byte-wide registers at their printed offsets
// Notes: function codes are two bits wide on every pin
package upfc_pkg;
   localparam int UPFC_ADDR_W = 12;
   localparam int UPFC_PINS = 4;
   localparam logic [11:0] UPFC_CTS_CFG_ADDR = 12'h026;
   localparam logic [11:0] UPFC_HDX_CFG_ADDR = 12'h027;
   localparam logic [11:0] UPFC_TXA_CFG_ADDR = 12'h028;
   localparam logic [11:0] UPFC_RXA_CFG_ADDR = 12'h029;
   localparam int UPFC_PU_DIS_BIT = 7;
   localparam int UPFC_PD_EN_BIT = 6;
   localparam int UPFC_FUNC_HI = 1;
   localparam int UPFC_FUNC_LO = 0;
   localparam logic [7:0] UPFC_CFG_RESET = 8'h00;
   localparam logic [7:0] UPFC_CFG_MASK = 8'hC3;
   localparam logic [1:0] UPFC_FN_GP_IN = 2'h0;
   localparam logic [1:0] UPFC_FN_GP_OD = 2'h1;
   localparam logic [1:0] UPFC_FN_GP_PP = 2'h2;
   localparam logic [1:0] UPFC_FN_DEDIC = 2'h3;
   localparam int UPFC_IDX_CTS = 0;
   localparam int UPFC_IDX_HDX = 1;
   localparam int UPFC_IDX_TXA = 2;
   localparam int UPFC_IDX_RXA = 3;
endpackage : upfc_pkg

// ---- src/upfc_top.sv ----
// Purpose: pin function, pull and driver control for four uart-side pins
// Assumes: registers written through a simple byte port of the register map
// Notes: pin inputs pass three flip-flops and a settle register before use
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - bit 7 set disables the pin pull-up; clear leaves it enabled.
// - bit 6 enables pull-down, never while pull-up is enabled.
// - pull-up and pull-down are ignored in any output mode.
// - codes 00, 01, 10 select gp input, open-drain and push-pull output.
// - clear-to-send code 11 makes the pin the flow-control input.
// - half-duplex pin code 11 drives transceiver direction push-pull.
// - transmit-activity pin code 11 drives a push-pull toggle output.
// - receive-activity pin code 11 drives a push-pull toggle output.
module upfc_top
   import upfc_pkg::*;
#(
   parameter int NUM_PINS = UPFC_PINS // pins served, one register each
)
(
   input wire logic clock_in, // core clock, 125 MHz
   input wire logic rst_n_in, // async reset, active low
   input wire logic [11:0] reg_addr_in, // register byte address
   input wire logic reg_wr_in, // write strobe
   input wire logic [7:0] reg_wdata_in, // write data
   output logic [7:0] reg_rdata_out, // read data, zero off map
   input wire logic [3:0] gpio_out_in, // gp output level per pin
   output logic [3:0] gpio_in_out, // synchronised pin level
   output logic cts_out, // synchronised clear-to-send level
   output logic cts_sel_out, // clear-to-send function selected
   input wire logic hdx_enable_in, // direction enable from uart
   input wire logic tx_toggle_in, // transmit activity toggle
   input wire logic rx_toggle_in, // receive activity toggle
   input wire logic [3:0] pin_in, // pad input levels
   output logic [3:0] pin_out, // pad output levels
   output logic [3:0] pin_oe_out, // pad output enables
   output logic [3:0] pull_up_out, // pull-up enables
   output logic [3:0] pull_down_out // pull-down enables
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // each pin owns one register at a fixed offset, so the pin count
   // cannot move without new offsets in the package
   generate
      if (NUM_PINS != UPFC_PINS) begin : g_bad_pins
         $error("pin count does not match the mapped registers");
      end
   endgenerate

   localparam logic [11:0] CFG_ADDR [UPFC_PINS] = '{UPFC_CTS_CFG_ADDR,
      UPFC_HDX_CFG_ADDR, UPFC_TXA_CFG_ADDR, UPFC_RXA_CFG_ADDR};

   function automatic logic is_output(input logic [1:0] code, input int idx);
      is_output = (code == UPFC_FN_GP_OD) || (code == UPFC_FN_GP_PP) ||
         ((code == UPFC_FN_DEDIC) && (idx != UPFC_IDX_CTS));
   endfunction : is_output

   // shared by the write path and the read mux
   function automatic logic cfg_hit(input logic [11:0] addr,
      input int idx);
      cfg_hit = (addr == CFG_ADDR[idx]);
   endfunction : cfg_hit

   logic [7:0] cfg [UPFC_PINS];
   logic [3:0] sync1, sync2, sync3, pin_level;
   wire [3:0] dedic_level = {rx_toggle_in, tx_toggle_in, hdx_enable_in,
      1'b0};

   // ----------------------------------------
   // per-pin config and pad control
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < UPFC_PINS; g++) begin : g_pin
         wire [1:0] fn = cfg[g][UPFC_FUNC_HI:UPFC_FUNC_LO];
         wire is_out = is_output(fn, g);
         wire pu = ~cfg[g][UPFC_PU_DIS_BIT] & ~is_out;
         wire pd = cfg[g][UPFC_PD_EN_BIT] & ~pu & ~is_out;
         assign pull_up_out[g] = pu;
         assign pull_down_out[g] = pd;
         assign pin_oe_out[g] = (fn == UPFC_FN_GP_PP) ||
            ((fn == UPFC_FN_GP_OD) && !gpio_out_in[g]) ||
            ((fn == UPFC_FN_DEDIC) && (g != UPFC_IDX_CTS));
         assign pin_out[g] = (fn == UPFC_FN_DEDIC) ? dedic_level[g] :
            (fn == UPFC_FN_GP_OD) ? 1'b0 : gpio_out_in[g];
      end
   endgenerate

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // one process for all pins keeps a single driver on the array
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < UPFC_PINS; i++) begin
            cfg[i] <= UPFC_CFG_RESET;
         end
      end else begin
         for (int i = 0; i < UPFC_PINS; i++) begin
            if (reg_wr_in && cfg_hit(reg_addr_in, i)) begin
               // reserved bits are not stored, so they read zero
               cfg[i] <= reg_wdata_in & UPFC_CFG_MASK;
            end
         end
      end
   end

   // ----------------------------------------
   // input synchroniser
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
         pin_level <= 4'h0;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < UPFC_PINS; i++) begin
            if (sync2[i] == sync3[i]) begin
               pin_level[i] <= sync3[i];
            end
         end
      end
   end

   assign gpio_in_out = pin_level;
   assign cts_sel_out = (cfg[UPFC_IDX_CTS][1:0] == UPFC_FN_DEDIC);
   assign cts_out = pin_level[UPFC_IDX_CTS];

   // ----------------------------------------
   // read back
   // ----------------------------------------
   always_comb begin
      reg_rdata_out = 8'h00;
      for (int i = 0; i < UPFC_PINS; i++) begin
         if (cfg_hit(reg_addr_in, i)) begin
            reg_rdata_out = cfg[i];
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // whole-block and single-pin checks first, then the rules pin by pin so that a
   // slip in one pin's decode cannot hide behind the others
   pull_exclusive_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      (pull_up_out & pull_down_out) == 4'h0)
      else $error("both pulls on");

   pull_out_off_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      pin_oe_out[1] |-> !pull_up_out[1] && !pull_down_out[1])
      else $error("pull active while driving");

   pu_default_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      (cfg[0] == UPFC_CFG_RESET) |-> pull_up_out[0])
      else $error("pull-up off at default");

   cts_input_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      cts_sel_out |-> !pin_oe_out[UPFC_IDX_CTS])
      else $error("cts pin driven");

   cts_pulls_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      cts_sel_out |->
      pull_up_out[UPFC_IDX_CTS] == !cfg[UPFC_IDX_CTS][UPFC_PU_DIS_BIT])
      else $error("cts input pull wrong");

   hdx_drive_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      (cfg[UPFC_IDX_HDX][1:0] == UPFC_FN_DEDIC) |->
      pin_oe_out[UPFC_IDX_HDX] && pin_out[UPFC_IDX_HDX] == hdx_enable_in)
      else $error("direction enable not driven");

   tx_toggle_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      (cfg[UPFC_IDX_TXA][1:0] == UPFC_FN_DEDIC) |->
      pin_oe_out[UPFC_IDX_TXA] && pin_out[UPFC_IDX_TXA] == tx_toggle_in)
      else $error("tx toggle not driven");

   rx_toggle_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      (cfg[UPFC_IDX_RXA][1:0] == UPFC_FN_DEDIC) |->
      pin_oe_out[UPFC_IDX_RXA] && pin_out[UPFC_IDX_RXA] == rx_toggle_in)
      else $error("rx toggle not driven");

   write_read_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      reg_wr_in && reg_addr_in == UPFC_TXA_CFG_ADDR ##1
      reg_addr_in == UPFC_TXA_CFG_ADDR |->
      reg_rdata_out == ($past(reg_wdata_in) & UPFC_CFG_MASK))
      else $error("readback wrong");

   od_drive_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      (cfg[UPFC_IDX_RXA][1:0] == UPFC_FN_GP_OD) |->
      (pin_oe_out[3] == !gpio_out_in[3]) && !pin_out[3])
      else $error("open drain wrong");

   // the first reset edge may still see unset flops, so look one later
   reset_default_a: assert property (
      @(posedge clock_in)
      !rst_n_in ##1 !rst_n_in |-> pull_up_out == 4'hF &&
      pin_oe_out == 4'h0 && pull_down_out == 4'h0 && reg_rdata_out == 8'h00)
      else $error("reset state wrong");

   generate
      for (g = 0; g < UPFC_PINS; g++) begin : g_chk
         wire [1:0] code = cfg[g][UPFC_FUNC_HI:UPFC_FUNC_LO];
         wire pu_dis = cfg[g][UPFC_PU_DIS_BIT];
         wire pd_en = cfg[g][UPFC_PD_EN_BIT];

         out_pulls_off_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            (code == UPFC_FN_GP_OD || code == UPFC_FN_GP_PP) |->
            !pull_up_out[g] && !pull_down_out[g])
            else $error("pull on in output mode");

         pu_follow_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            (code == UPFC_FN_GP_IN) |-> pull_up_out[g] == !pu_dis)
            else $error("pull-up does not follow its bit");

         pd_follow_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            (code == UPFC_FN_GP_IN) |->
            pull_down_out[g] == (pu_dis && pd_en))
            else $error("pull-down does not follow its bit");

         pp_drive_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            (code == UPFC_FN_GP_PP) |->
            pin_oe_out[g] && pin_out[g] == gpio_out_in[g])
            else $error("push-pull pin wrong");

         od_pin_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            (code == UPFC_FN_GP_OD) |->
            pin_oe_out[g] == !gpio_out_in[g] && !pin_out[g])
            else $error("open-drain pin wrong");

         in_quiet_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            (code == UPFC_FN_GP_IN) |-> !pin_oe_out[g])
            else $error("input pin driven");

         dedic_drive_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            (code == UPFC_FN_DEDIC && g != UPFC_IDX_CTS) |->
            pin_oe_out[g] && !pull_up_out[g] && !pull_down_out[g])
            else $error("dedicated output wrong");

         rsv_clear_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            (cfg[g] & ~UPFC_CFG_MASK) == 8'h00)
            else $error("reserved bits stored");

         cfg_keep_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            !(reg_wr_in && cfg_hit(reg_addr_in, g)) |=> $stable(cfg[g]))
            else $error("register changed without a write");

         level_take_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            sync2[g] == sync3[g] |=> gpio_in_out[g] == $past(sync3[g]))
            else $error("settled pin level not taken");

         level_hold_a: assert property (
            @(posedge clock_in) disable iff (!rst_n_in)
            sync2[g] != sync3[g] |=> $stable(gpio_in_out[g]))
            else $error("unsettled pin level taken");
      end
   endgenerate

endmodule : upfc_top

`default_nettype wire

// ---- sim/upfc_pad_model.sv ----
// Purpose: far-side transceiver and pad wire for the four pins
// Assumes: far side drives a pin only while its enable is high
// Notes: an undriven, unpulled pad toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module upfc_pad_model (
   input wire logic clock_in, // core clock
   input wire logic [3:0] drv_in, // block pad levels
   input wire logic [3:0] oe_in, // block output enables
   input wire logic [3:0] pu_in, // pull-up enables
   input wire logic [3:0] pd_in, // pull-down enables
   input wire logic [3:0] ext_en_in, // far side drives
   input wire logic [3:0] ext_val_in, // far side level
   output logic [3:0] pad_out // resolved wire level
);
   logic noise = 1'b0;
   always @(posedge clock_in) noise <= ~noise;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pad_out[i] = oe_in[i] ? drv_in[i] : ext_en_in[i] ? ext_val_in[i] :
            pu_in[i] ? 1'b1 : pd_in[i] ? 1'b0 : noise;
      end
   end
endmodule : upfc_pad_model
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the uart pin function block
// Assumes: a write shows one edge after its strobe
// Notes: every code on every pin, pulls both ways
`timescale 1ns/1ps
`default_nettype none
module tb;
   import upfc_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, hdx = 1'b1, txt = 1'b0;
   logic rxt = 1'b1, in_m;
   logic [11:0] addr = 12'h000;
   logic [7:0] wd = 8'h00, cfg;
   logic [3:0] go = 4'hA, ext_en = 4'h0, ext_v = 4'h0, fn;
   logic [1:0] eo;
   wire logic [7:0] rd;
   wire logic [3:0] gin, pad, po, poe, pu, pd;
   wire logic cts, cts_sel;
   int failures = 0, n_compared = 0, cyc = 0;
   initial forever #4 clk = ~clk;
   upfc_top dut (.clock_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rd),
      .gpio_out_in(go), .gpio_in_out(gin), .cts_out(cts),
      .cts_sel_out(cts_sel), .hdx_enable_in(hdx), .tx_toggle_in(txt),
      .rx_toggle_in(rxt), .pin_in(pad), .pin_out(po), .pin_oe_out(poe),
      .pull_up_out(pu), .pull_down_out(pd));
   upfc_pad_model far (.clock_in(clk), .drv_in(po), .oe_in(poe),
      .pu_in(pu), .pd_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_v),
      .pad_out(pad));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic give_verdict();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // hang guard: the whole run needs about a hundred cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 chk({poe, pu}, 8'h0F);
      chk({4'h0, pd}, 8'h00);
      @(posedge clk);
      rst_n <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         addr <= UPFC_CTS_CFG_ADDR + 12'(p);
         #1 chk(rd, 8'h00);
         @(posedge clk);
      end
      fn = {rxt, txt, hdx, 1'b0};
      for (int p = 0; p < 4; p++) begin
         for (int c = 0; c < 8; c++) begin
            cfg = {c[2], 1'b1, 4'h0, c[1:0]};
            // cts code 11 assumes rts and the modem pins set elsewhere
            wr_reg(UPFC_CTS_CFG_ADDR + 12'(p), cfg);
            in_m = c[1:0] == 2'h0 || (p == 0 && c[1:0] == 2'h3);
            eo = c[1:0] == 2'h1 ? {~go[p], 1'b0} : c[1:0] == 2'h2 ?
               {1'b1, go[p]} : (c[1:0] == 2'h3 && p != 0) ? {1'b1, fn[p]} : 2'h0;
            #1 chk(rd, cfg);
            chk({4'h0, poe[p], poe[p] & po[p], pu[p], pd[p]},
               {4'h0, eo, in_m & !c[2],
               in_m & c[2]});
            if (p == 0)
               chk({7'h0, cts_sel}, {7'h0, c[1:0] == 2'h3});
            @(posedge clk);
         end
      end
      wr_reg(12'h02A, 8'hFF);
      #1 chk(rd, 8'h00);
      @(posedge clk);
      wr_reg(UPFC_CTS_CFG_ADDR, 8'h00);
      repeat (5) @(posedge clk);
      ext_en <= 4'h1;
      ext_v <= 4'h0;
      repeat (3) @(posedge clk);
      #1 chk({6'h0, gin[0], cts}, 8'h03);
      @(posedge clk);
      #1 chk({6'h0, gin[0], cts}, 8'h00);
      // pins 1 to 3 are still in code 11: flip what they carry
      @(posedge clk);
      hdx <= 1'b0;
      txt <= 1'b1;
      rxt <= 1'b0;
      #1 chk({5'h0, po[3:1]}, 8'h02);
      chk({5'h0, poe[3:1]}, 8'h07);
      repeat (4) @(posedge clk);
      #1 chk({5'h0, gin[3:1]}, 8'h02);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
